// File: logic/jbi_pkg.sv
// ----------------------------------------------------------------------------
// Notes on behaviour
// [RULE1] bypass path is exactly one stage between serial in and serial out
// [RULE2] bypass selected for bypass, clamp and high-impedance instructions
// [RULE3] identity path is 32 shift stages plus a 32-bit latched output
// [RULE4] identity path selected under idcode and in test-logic-reset
// [RULE5] bypass code 111 loads while instruction capture shifts out x01
// [RULE6] after reset a data scan shifts identity word out lsb first
// [RULE7] asynchronous test reset abandons any scan at once
// [RULE8] instruction register is three bits, shift stage plus latched output
// [RULE9] identity word: bit0 one, 11-bit maker, 16-bit part, 4-bit version
// [RULE10] identity word loads into shift path on capture-dr edge
// [RULE11] high-impedance instruction floats all digital outputs, bypass path used
// [RULE12] bypass stage captures zero in capture-dr
package jbi_pkg;

  // --------------------------------------------------------------------------
  // widths and codes
  // --------------------------------------------------------------------------
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLE = 3'h2;
  localparam logic [2:0] INS_CLAMP = 3'h3;
  localparam logic [2:0] INS_HIGHZ = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic [0:0] BYP_CAPTURE = 1'h0;

  // identity fields, values arbitrary
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h5a3c;
  localparam logic [10:0] ID_MAKER = 11'h2b5;
  localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'h1};

  // --------------------------------------------------------------------------
  // tap states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SELDR = 16'h0004, ST_CAPDR = 16'h0008,
    ST_SHDR = 16'h0010, ST_EX1DR = 16'h0020, ST_PSDR = 16'h0040, ST_EX2DR = 16'h0080,
    ST_UPDR = 16'h0100, ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR = 16'h0800,
    ST_EX1IR = 16'h1000, ST_PSIR = 16'h2000, ST_EX2IR = 16'h4000, ST_UPIR = 16'h8000
  } jbi_state_type;

  typedef struct packed {
    logic serialOut;
    logic serialOutEn_n;
    logic outputsFloat;
  } jbi_out_type;

endpackage : jbi_pkg

// File: logic/jbi_tap.sv
`timescale 1ns/1ps
module jbi_tap (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic test_shift_clock,
  input wire logic test_mode_select,
  input wire logic test_serial_in,
  input wire logic testReset_n,
  output jbi_pkg::jbi_out_type outBus,
  output logic [2:0] curInstr,
  output logic [31:0] idLatched
);

  // --------------------------------------------------------------------------
  // pin synchronisers, change accepted when stages two and three agree
  // --------------------------------------------------------------------------
  // three stages per pin; stage one is only ever read by stage two
  logic [2:0] tckSync_ff, tmsSync_ff, tdiSync_ff;
  logic tckStable_ff, tmsStable_ff, tdiStable_ff;
  logic trstA_ff, trstB_ff;
  logic tckRise, tckFall;

  // pins are sampled by the system clock, not used as clocks
  // clkEn low freezes every stage, synchronisers included
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tckSync_ff <= 3'h0;
      tmsSync_ff <= 3'h7;
      tdiSync_ff <= 3'h7;
      tckStable_ff <= 1'h0;
      tmsStable_ff <= 1'h1;
      tdiStable_ff <= 1'h1;
    end
    else if (clkEn)
    begin
      tckSync_ff <= {tckSync_ff[1:0], test_shift_clock};
      tmsSync_ff <= {tmsSync_ff[1:0], test_mode_select};
      tdiSync_ff <= {tdiSync_ff[1:0], test_serial_in};
      if (tckSync_ff[1] == tckSync_ff[2])
        tckStable_ff <= tckSync_ff[2];
      if (tmsSync_ff[1] == tmsSync_ff[2])
        tmsStable_ff <= tmsSync_ff[2];
      if (tdiSync_ff[1] == tdiSync_ff[2])
        tdiStable_ff <= tdiSync_ff[2];
    end
  end

  // edges come from agreeing stages, so a one-clock glitch never counts
  assign tckRise = (tckSync_ff[1] == tckSync_ff[2]) && tckSync_ff[2] && !tckStable_ff;
  assign tckFall = (tckSync_ff[1] == tckSync_ff[2]) && !tckSync_ff[2] && tckStable_ff;

  // test reset is asserted asynchronously, released through two stages
  // without this, a release close to a test clock edge could act on half a rise
  always_ff @(posedge clock or negedge testReset_n or negedge rst_n)
  begin
    if (!rst_n || !testReset_n)
    begin
      trstA_ff <= 1'h0; // see [RULE7]
      trstB_ff <= 1'h0;
    end
    else if (clkEn)
    begin
      trstA_ff <= 1'h1;
      trstB_ff <= trstA_ff;
    end
  end

  // --------------------------------------------------------------------------
  // controller state
  // --------------------------------------------------------------------------
  // controller, instruction and data register state
  jbi_pkg::jbi_state_type state_ff, nxt_state;
  logic [2:0] irShift_ff, irLatch_ff;
  logic [31:0] idShift_ff, idOut_ff;
  logic bypass_ff;
  logic selBypass, selId;
  logic tdoNext;

  // standard sixteen-state walk on mode select
  // mode select is the synchronised copy, settled well before the rise is seen
  always_comb
  begin
    case (state_ff)
      jbi_pkg::ST_TLR: nxt_state = tmsStable_ff ? jbi_pkg::ST_TLR : jbi_pkg::ST_RTI;
      jbi_pkg::ST_RTI: nxt_state = tmsStable_ff ? jbi_pkg::ST_SELDR : jbi_pkg::ST_RTI;
      jbi_pkg::ST_SELDR: nxt_state = tmsStable_ff ? jbi_pkg::ST_SELIR : jbi_pkg::ST_CAPDR;
      jbi_pkg::ST_CAPDR: nxt_state = tmsStable_ff ? jbi_pkg::ST_EX1DR : jbi_pkg::ST_SHDR;
      jbi_pkg::ST_SHDR: nxt_state = tmsStable_ff ? jbi_pkg::ST_EX1DR : jbi_pkg::ST_SHDR;
      jbi_pkg::ST_EX1DR: nxt_state = tmsStable_ff ? jbi_pkg::ST_UPDR : jbi_pkg::ST_PSDR;
      jbi_pkg::ST_PSDR: nxt_state = tmsStable_ff ? jbi_pkg::ST_EX2DR : jbi_pkg::ST_PSDR;
      jbi_pkg::ST_EX2DR: nxt_state = tmsStable_ff ? jbi_pkg::ST_UPDR : jbi_pkg::ST_SHDR;
      jbi_pkg::ST_UPDR: nxt_state = tmsStable_ff ? jbi_pkg::ST_SELDR : jbi_pkg::ST_RTI;
      jbi_pkg::ST_SELIR: nxt_state = tmsStable_ff ? jbi_pkg::ST_TLR : jbi_pkg::ST_CAPIR;
      jbi_pkg::ST_CAPIR: nxt_state = tmsStable_ff ? jbi_pkg::ST_EX1IR : jbi_pkg::ST_SHIR;
      jbi_pkg::ST_SHIR: nxt_state = tmsStable_ff ? jbi_pkg::ST_EX1IR : jbi_pkg::ST_SHIR;
      jbi_pkg::ST_EX1IR: nxt_state = tmsStable_ff ? jbi_pkg::ST_UPIR : jbi_pkg::ST_PSIR;
      jbi_pkg::ST_PSIR: nxt_state = tmsStable_ff ? jbi_pkg::ST_EX2IR : jbi_pkg::ST_PSIR;
      jbi_pkg::ST_EX2IR: nxt_state = tmsStable_ff ? jbi_pkg::ST_UPIR : jbi_pkg::ST_SHIR;
      jbi_pkg::ST_UPIR: nxt_state = tmsStable_ff ? jbi_pkg::ST_SELDR : jbi_pkg::ST_RTI;
      default: nxt_state = jbi_pkg::ST_TLR;
    endcase
  end

  // state moves on the sampled test clock rise; reset drops it at once
  always_ff @(posedge clock or negedge testReset_n or negedge rst_n)
  begin
    if (!rst_n || !testReset_n)
      state_ff <= jbi_pkg::ST_TLR; // see [RULE7]
    else if (clkEn && tckRise && trstB_ff)
      state_ff <= nxt_state;
  end

  // --------------------------------------------------------------------------
  // instruction register
  // --------------------------------------------------------------------------
  // capture and shift on the rise, update on the fall in update-ir
  always_ff @(posedge clock or negedge testReset_n or negedge rst_n)
  begin
    if (!rst_n || !testReset_n)
    begin
      irShift_ff <= jbi_pkg::IR_CAPTURE;
      irLatch_ff <= jbi_pkg::INS_IDCODE; // see [RULE4]
    end
    else if (clkEn && trstB_ff)
    begin
      if (tckRise && state_ff == jbi_pkg::ST_CAPIR)
        irShift_ff <= jbi_pkg::IR_CAPTURE; // see [RULE5]
      else if (tckRise && state_ff == jbi_pkg::ST_SHIR)
        irShift_ff <= {tdiStable_ff, irShift_ff[2:1]}; // see [RULE8]
      // latch on falling edge while in update-ir
      if (tckFall && state_ff == jbi_pkg::ST_UPIR)
        irLatch_ff <= irShift_ff; // see [RULE8]
      else if (state_ff == jbi_pkg::ST_TLR)
        irLatch_ff <= jbi_pkg::INS_IDCODE; // see [RULE4]
    end
  end

  // register selection from the current instruction
  // boundary-scan codes borrow bypass, since that register lives elsewhere
  assign selBypass = (irLatch_ff == jbi_pkg::INS_BYPASS) || (irLatch_ff == jbi_pkg::INS_CLAMP)
    || (irLatch_ff == jbi_pkg::INS_HIGHZ) || (irLatch_ff == jbi_pkg::INS_EXTEST)
    || (irLatch_ff == jbi_pkg::INS_SAMPLE); // see [RULE2]
  assign selId = (irLatch_ff == jbi_pkg::INS_IDCODE)
    || (state_ff == jbi_pkg::ST_TLR); // see [RULE4]

  // --------------------------------------------------------------------------
  // data registers: one-stage bypass and 32-stage identity
  // --------------------------------------------------------------------------
  // capture and shift act on the detected test clock rise
  // the identity path moves toward bit zero, which feeds the serial output
  always_ff @(posedge clock or negedge testReset_n or negedge rst_n)
  begin
    if (!rst_n || !testReset_n)
    begin
      bypass_ff <= jbi_pkg::BYP_CAPTURE;
      idShift_ff <= jbi_pkg::ID_WORD; // see [RULE6]
      idOut_ff <= jbi_pkg::ID_WORD;
    end
    else if (clkEn && trstB_ff)
    begin
      if (tckRise && state_ff == jbi_pkg::ST_CAPDR)
      begin
        bypass_ff <= jbi_pkg::BYP_CAPTURE; // see [RULE12]
        if (selId)
          idShift_ff <= jbi_pkg::ID_WORD; // see [RULE10] [RULE9]
      end
      else if (tckRise && state_ff == jbi_pkg::ST_SHDR)
      begin
        bypass_ff <= tdiStable_ff; // see [RULE1]
        if (selId)
          idShift_ff <= {tdiStable_ff, idShift_ff[31:1]}; // see [RULE3] [RULE6]
      end
      // latched identity output follows update-dr fall
      if (tckFall && state_ff == jbi_pkg::ST_UPDR && selId)
        idOut_ff <= idShift_ff; // see [RULE3]
    end
  end

  // --------------------------------------------------------------------------
  // serial output, changes on the test clock fall
  // --------------------------------------------------------------------------
  // pick the stage that feeds the serial output
  always_comb
  begin
    if (state_ff == jbi_pkg::ST_SHIR)
      tdoNext = irShift_ff[0];
    else if (selId)
      tdoNext = idShift_ff[0]; // see [RULE6]
    else if (selBypass)
      tdoNext = bypass_ff; // see [RULE1] [RULE2]
    else
      tdoNext = bypass_ff; // codes with no register of their own fall back to bypass
  end

  // every output is registered; reset shows an idle, released port
  // limitation: the output lags the pin fall by the synchroniser delay
  always_ff @(posedge clock or negedge testReset_n or negedge rst_n)
  begin
    if (!rst_n || !testReset_n)
    begin
      outBus.serialOut <= 1'h1;
      outBus.serialOutEn_n <= 1'h1;
      outBus.outputsFloat <= 1'h0;
      curInstr <= jbi_pkg::INS_IDCODE;
      idLatched <= jbi_pkg::ID_WORD;
    end
    else if (clkEn)
    begin
      if (tckFall)
      begin
        outBus.serialOut <= tdoNext;
        // driven only while shifting; low enable means driving
        outBus.serialOutEn_n <= !(state_ff == jbi_pkg::ST_SHIR || state_ff == jbi_pkg::ST_SHDR);
      end
      outBus.outputsFloat <= (irLatch_ff == jbi_pkg::INS_HIGHZ); // see [RULE11]
      curInstr <= irLatch_ff;
      idLatched <= idOut_ff;
    end
  end

endmodule : jbi_tap

// File: sim/jbi_tester.sv
`timescale 1ns/1ps
// ------------------------------
// far-side test controller
// ------------------------------
module jbi_tester (
  input wire logic clock,
  input wire logic serialOut,
  output logic tck,
  output logic tms,
  output logic tdi
);
  // test clock idles low between frames
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // one 200 ns test clock; serial out is taken late in the high phase
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clock);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge clock);
    tck <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    q = serialOut;
    @(posedge clock);
    tck <= 1'b0;
  endtask : step
endmodule : jbi_tester

// File: sim/jbi_tap_monitor.sv
`timescale 1ns/1ps
// ------------------------------
// port checker
// ------------------------------
module jbi_tap_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic test_shift_clock,
  input wire logic testReset_n,
  input wire jbi_pkg::jbi_out_type outBus,
  input wire logic [2:0] curInstr,
  input wire logic [31:0] idLatched
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // test reset acts without a test clock
  AST_TRST_INSTR: assert property (
    !testReset_n |=> curInstr == jbi_pkg::INS_IDCODE) else $error("instr kept");
  AST_TRST_OUT: assert property (
    !testReset_n |-> outBus.serialOutEn_n && !outBus.outputsFloat) else $error("out kept");
  AST_TRST_HOLD: assert property (
    $rose(testReset_n) |-> (curInstr == jbi_pkg::INS_IDCODE)[*8]) else $error("id lost");
  AST_ID_WORD: assert property (
    idLatched == {jbi_pkg::ID_VERSION, jbi_pkg::ID_PART, jbi_pkg::ID_MAKER, 1'h1})
    else $error("id word");
  // float may lag or lead the visible copy by two clocks
  AST_FLOAT_ON: assert property (disable iff (!rst_n || !testReset_n)
    (curInstr == jbi_pkg::INS_HIGHZ)[*3] |-> outBus.outputsFloat) else $error("no float");
  AST_FLOAT_OFF: assert property (
    (curInstr != jbi_pkg::INS_HIGHZ)[*5] |-> !$past(outBus.outputsFloat, 2))
    else $error("float");
  // outputs move only after a detected fall of the test clock, or when test-logic-reset reloads idcode
  AST_OUT_ON_FALL: assert property (disable iff (!rst_n || !testReset_n)
    $changed(outBus) |-> !$past(test_shift_clock, 2) && !$past(test_shift_clock, 3))
    else $error("out off fall");
  AST_INSTR_ON_FALL: assert property (disable iff (!rst_n || !testReset_n)
    $changed(curInstr) |-> !$past(test_shift_clock, 2) && !$past(test_shift_clock, 3))
    else $error("instr off fall");
endmodule : jbi_tap_monitor
bind jbi_tap jbi_tap_monitor u_mon (.clock(clock), .rst_n(rst_n),
  .test_shift_clock(test_shift_clock), .testReset_n(testReset_n), .outBus(outBus),
  .curInstr(curInstr), .idLatched(idLatched));

// File: sim/jbi_tap_bench.sv
`timescale 1ns/1ps
// ------------------------------
// bench
// ------------------------------
module jbi_tap_bench;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic testReset_n = 1'h0;
  logic clkEn = 1'h1;
  logic tck;
  logic tms;
  logic tdi;
  jbi_pkg::jbi_out_type outBus;
  logic [2:0] curInstr;
  logic [31:0] idLatched;
  logic [31:0] idExp = {jbi_pkg::ID_VERSION, jbi_pkg::ID_PART, jbi_pkg::ID_MAKER, 1'b1};
  int num_errors = 0;
  int checks = 0;
  always #12.5 clock = ~clock;
  jbi_tap u_dut (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .test_shift_clock(tck),
    .test_mode_select(tms), .test_serial_in(tdi), .testReset_n(testReset_n),
    .outBus(outBus), .curInstr(curInstr), .idLatched(idLatched));
  jbi_tester u_tester (.clock(clock), .serialOut(outBus.serialOut), .tck(tck),
    .tms(tms), .tdi(tdi));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // mode select path, lsb first
  task automatic walk(input logic [7:0] path, input int n);
    logic q;
    for (int i = 0; i < n; i++)
      u_tester.step(path[i], 1'b0, q);
  endtask : walk
  // shift n bits; last is the exit bit
  task automatic shift(input int n, input logic [31:0] din, input logic last,
    output logic [31:0] dout);
    dout = 32'h0;
    for (int i = 0; i < n; i++)
      u_tester.step((i == n - 1) ? last : 1'b0, din[i], dout[i]);
  endtask : shift
  // from reset state, data scan reads the identity word
  task automatic t_idscan();
    logic [31:0] d;
    walk(8'h02, 4);
    shift(32, idExp, 1'b1, d);
    check("id scan", d, idExp);
    check("id latched", idLatched, idExp);
    walk(8'h01, 2);
  endtask : t_idscan
  // load an instruction, then use the one-stage path
  task automatic t_bypass(input logic [2:0] code);
    logic [31:0] d;
    walk(8'h03, 4);
    shift(3, 32'(code), 1'b1, d);
    check("ir capture", 32'(d[1:0]), 32'h1);
    walk(8'h01, 2);
    check("instr", 32'(curInstr), 32'(code));
    check("float", 32'(outBus.outputsFloat), 32'(code == jbi_pkg::INS_HIGHZ));
    walk(8'h01, 3);
    shift(9, 32'hb5, 1'h1, d);
    check("bypass lead", 32'(d[0]), 32'h0);
    check("bypass path", d, 32'h16a);
    walk(8'h01, 2);
  endtask : t_bypass
  // clock enable low: test clock edges go unseen, so the port stays put
  task automatic t_freeze();
    clkEn <= 1'h0;
    walk(8'h03, 4);
    repeat (6) @(posedge clock);
    check("frozen enable", 32'(outBus.serialOutEn_n), 32'h1);
    check("frozen instr", 32'(curInstr), 32'(jbi_pkg::INS_HIGHZ));
    check("frozen float", 32'(outBus.outputsFloat), 32'h1);
    clkEn <= 1'h1;
    repeat (4) @(posedge clock);
    t_bypass(jbi_pkg::INS_BYPASS);
  endtask : t_freeze
  // test reset mid-scan, then identity is selected again
  task automatic t_trst();
    logic [31:0] d;
    walk(8'h01, 3);
    shift(5, 32'h1f, 1'b0, d);
    testReset_n <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("reset", 32'({curInstr, outBus}), 32'({jbi_pkg::INS_IDCODE, 3'h6}));
    @(posedge clock);
    testReset_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_idscan();
  endtask : t_trst
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // about 180 test clocks expected; cut a hang well past that
  initial
  begin
    #200us;
    num_errors++;
    complete_run();
  end
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    testReset_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_idscan();
    t_bypass(jbi_pkg::INS_BYPASS);
    t_bypass(jbi_pkg::INS_CLAMP);
    t_bypass(jbi_pkg::INS_HIGHZ);
    t_freeze();
    t_trst();
    complete_run();
  end
endmodule : jbi_tap_bench
